// File: pkg/gap_pkg.sv
// gap_pkg: register map, field positions, alarm indices and carrier types
// for the generator-set alarm and protection block.
// assumes a 125 MHz system clock and a plain address/strobe register port.
package gap_pkg;
	// ==========================================================
	// timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int TICK_PERIOD_NS = 1000000; // 1 ms time base for the excess period
	localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
	// ==========================================================
	// widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int MEAS_W = 16;
	localparam int EF_ACC_W = 24;
	localparam int EF_ACC_SHIFT = 8;
	localparam int CRANK_W = 4;
	// ==========================================================
	// register byte addresses
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_HC_TRIP = 8'h04;
	localparam logic [7:0] ADR_HC_PERIOD = 8'h08;
	localparam logic [7:0] ADR_OS_TRIP = 8'h0c;
	localparam logic [7:0] ADR_OS_MARGIN = 8'h10;
	localparam logic [7:0] ADR_US_TRIP = 8'h14;
	localparam logic [7:0] ADR_OIL_TRIP = 8'h18;
	localparam logic [7:0] ADR_TEMP_TRIP = 8'h1c;
	localparam logic [7:0] ADR_FUEL_LIMIT = 8'h20;
	localparam logic [7:0] ADR_EF_TRIP = 8'h24;
	localparam logic [7:0] ADR_EF_CURVE = 8'h28;
	localparam logic [7:0] ADR_CRANK_MAX = 8'h2c;
	localparam logic [7:0] ADR_STATUS = 8'h30;
	localparam logic [7:0] ADR_CAUSE = 8'h34;
	// control register fields
	localparam int CTRL_LATCH_ALL = 0;
	localparam int CTRL_PROT_DIS = 1;
	localparam int CTRL_ROT_DIR = 2;
	localparam int CTRL_OVERSHOOT = 3;
	localparam int CTRL_W = 4;
	localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
	localparam logic [MEAS_W-1:0] TRIP_RST = 16'hffff; // trips disarmed until set
	localparam logic [MEAS_W-1:0] LOW_TRIP_RST = 16'h0000;
	localparam logic [MEAS_W-1:0] PERIOD_RST = 16'h0064;
	localparam logic [CRANK_W-1:0] CRANK_RST = 4'h3;
	// ==========================================================
	// shutdown alarm indices
	localparam int SD_EARTH = 0;
	localparam int SD_START = 1;
	localparam int SD_ESTOP = 2;
	localparam int SD_OIL = 3;
	localparam int SD_TEMP = 4;
	localparam int SD_FUEL = 5;
	localparam int SD_ROT = 6;
	localparam int SD_OVER = 7;
	localparam int SD_UNDER = 8;
	localparam int SD_HICUR = 9;
	localparam int N_SD = 10;
	// status register fields above the shutdown bits
	localparam int ST_WARN = 16;
	localparam int ST_STOP = 17;
	localparam int ST_PROT_DIS = 18;
	// ==========================================================
	// measurements from the front-end logic
	typedef struct packed {
		logic [MEAS_W-1:0] speed;
		logic [MEAS_W-1:0] current;
		logic [MEAS_W-1:0] oil;
		logic [MEAS_W-1:0] temp;
		logic [MEAS_W-1:0] fuel_rate;
		logic [MEAS_W-1:0] ef_current;
	} gap_meas_t;
	// engine sequence flags from the start logic
	typedef struct packed {
		logic safety_on;
		logic starting;
		logic fired;
		logic crank_end;
		logic rot_valid;
		logic rot_reverse;
	} gap_seq_t;
endpackage

// File: src/gap_alarm.sv
// gap_alarm: alarm and protection logic of a generator-set controller.
// assumes measurements and sequence flags come from logic on mclk; the
// emergency stop and stop/reset button arrive from pins.
//
// What this block does
// - warn when output current exceeds trip
// - long high current escalates to shutdown
// - warning self-clears by default
// - latch-all option holds warning until reset
// - protections disabled: indicate, keep running
// - shutdowns latch and command stop
// - reset ignored while cause persists
// - safety-armed alarms resettable at rest
// - earth fault via inverse time curve
// - fail to start after crank attempts
// - failsafe emergency stop shuts down
// - low oil pressure after safety timer
// - high coolant temperature after safety timer
// - fuel usage above limit shuts down
// - wrong phase rotation shuts down
// - overspeed above trip shuts down
// - optional start-up overspeed margin
// - underspeed after safety timer
`timescale 1ns/1ps
module gap_alarm #(
	parameter int TICK_CYCLES = gap_pkg::TICK_CYCLES,
	parameter int MEAS_W = gap_pkg::MEAS_W
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [gap_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [gap_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [gap_pkg::DATA_W-1:0] reg_rdata,
	input wire gap_pkg::gap_meas_t meas,
	input wire gap_pkg::gap_seq_t seq,
	input wire logic estop_ok,
	input wire logic stop_reset_btn,
	output logic stop_cmd,
	output logic warn_hicur,
	output logic [gap_pkg::N_SD-1:0] sd_alarm,
	output logic prot_disabled
);
	// ==========================================================
	// pin synchronisers and time base
	logic estop_s1_reg, estop_s2_reg;
	logic btn_s1_reg, btn_s2_reg, btn_s3_reg;
	logic [$clog2(TICK_CYCLES+1)-1:0] div_reg;
	logic tick;
	logic rst_evt;

	// two flops on the estop pin, three on the button; estop uses the second stage, the button edge the second and third
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			estop_s1_reg <= 1'b0;
			estop_s2_reg <= 1'b0;
			btn_s1_reg <= 1'b0;
			btn_s2_reg <= 1'b0;
			btn_s3_reg <= 1'b0;
		end else begin
			estop_s1_reg <= estop_ok;
			estop_s2_reg <= estop_s1_reg;
			btn_s1_reg <= stop_reset_btn;
			btn_s2_reg <= btn_s1_reg;
			btn_s3_reg <= btn_s2_reg;
		end
	end
	// a held button resets once, on the press
	assign rst_evt = btn_s2_reg & ~btn_s3_reg;

	// 1 ms enable for the excess period
	assign tick = (div_reg == $bits(div_reg)'(TICK_CYCLES - 1));
	always_ff @(posedge mclk) begin
		if (sys_rst) div_reg <= '0;
		else div_reg <= tick ? '0 : div_reg + 1'b1;
	end

	// ==========================================================
	// register file
	logic [gap_pkg::CTRL_W-1:0] ctrl_reg;
	logic [MEAS_W-1:0] hc_trip_reg, hc_period_reg, os_trip_reg, os_margin_reg;
	logic [MEAS_W-1:0] us_trip_reg, oil_trip_reg, temp_trip_reg, fuel_limit_reg;
	logic [MEAS_W-1:0] ef_trip_reg, ef_curve_reg;
	logic [gap_pkg::CRANK_W-1:0] crank_max_reg;
	logic [gap_pkg::DATA_W-1:0] rdata_next;
	logic [gap_pkg::DATA_W-1:0] status_word, cause_word;
	logic latch_all, prot_dis, rot_dir, overshoot_en;
	logic [MEAS_W-1:0] wr_meas;

	assign wr_meas = reg_wdata[MEAS_W-1:0];
	assign latch_all = ctrl_reg[gap_pkg::CTRL_LATCH_ALL];
	assign prot_dis = ctrl_reg[gap_pkg::CTRL_PROT_DIS];
	assign rot_dir = ctrl_reg[gap_pkg::CTRL_ROT_DIR];
	assign overshoot_en = ctrl_reg[gap_pkg::CTRL_OVERSHOOT];

	// configuration writes; unmapped writes are dropped
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			ctrl_reg <= gap_pkg::CTRL_RST;
			hc_trip_reg <= gap_pkg::TRIP_RST;
			hc_period_reg <= gap_pkg::PERIOD_RST;
			os_trip_reg <= gap_pkg::TRIP_RST;
			os_margin_reg <= gap_pkg::LOW_TRIP_RST;
			us_trip_reg <= gap_pkg::LOW_TRIP_RST;
			oil_trip_reg <= gap_pkg::LOW_TRIP_RST;
			temp_trip_reg <= gap_pkg::TRIP_RST;
			fuel_limit_reg <= gap_pkg::TRIP_RST;
			ef_trip_reg <= gap_pkg::TRIP_RST;
			ef_curve_reg <= gap_pkg::TRIP_RST;
			crank_max_reg <= gap_pkg::CRANK_RST;
		end else if (reg_wr) begin
			case (reg_addr)
				gap_pkg::ADR_CTRL: ctrl_reg <= reg_wdata[gap_pkg::CTRL_W-1:0];
				gap_pkg::ADR_HC_TRIP: hc_trip_reg <= wr_meas;
				gap_pkg::ADR_HC_PERIOD: hc_period_reg <= wr_meas;
				gap_pkg::ADR_OS_TRIP: os_trip_reg <= wr_meas;
				gap_pkg::ADR_OS_MARGIN: os_margin_reg <= wr_meas;
				gap_pkg::ADR_US_TRIP: us_trip_reg <= wr_meas;
				gap_pkg::ADR_OIL_TRIP: oil_trip_reg <= wr_meas;
				gap_pkg::ADR_TEMP_TRIP: temp_trip_reg <= wr_meas;
				gap_pkg::ADR_FUEL_LIMIT: fuel_limit_reg <= wr_meas;
				gap_pkg::ADR_EF_TRIP: ef_trip_reg <= wr_meas;
				gap_pkg::ADR_EF_CURVE: ef_curve_reg <= wr_meas;
				gap_pkg::ADR_CRANK_MAX: crank_max_reg <= reg_wdata[gap_pkg::CRANK_W-1:0];
				default: ;
			endcase
		end
	end

	// read mux; unmapped addresses read zero
	always_comb begin
		rdata_next = '0;
		case (reg_addr)
			gap_pkg::ADR_CTRL: rdata_next = 32'(ctrl_reg);
			gap_pkg::ADR_HC_TRIP: rdata_next = 32'(hc_trip_reg);
			gap_pkg::ADR_HC_PERIOD: rdata_next = 32'(hc_period_reg);
			gap_pkg::ADR_OS_TRIP: rdata_next = 32'(os_trip_reg);
			gap_pkg::ADR_OS_MARGIN: rdata_next = 32'(os_margin_reg);
			gap_pkg::ADR_US_TRIP: rdata_next = 32'(us_trip_reg);
			gap_pkg::ADR_OIL_TRIP: rdata_next = 32'(oil_trip_reg);
			gap_pkg::ADR_TEMP_TRIP: rdata_next = 32'(temp_trip_reg);
			gap_pkg::ADR_FUEL_LIMIT: rdata_next = 32'(fuel_limit_reg);
			gap_pkg::ADR_EF_TRIP: rdata_next = 32'(ef_trip_reg);
			gap_pkg::ADR_EF_CURVE: rdata_next = 32'(ef_curve_reg);
			gap_pkg::ADR_CRANK_MAX: rdata_next = 32'(crank_max_reg);
			gap_pkg::ADR_STATUS: rdata_next = status_word;
			gap_pkg::ADR_CAUSE: rdata_next = cause_word;
			default: rdata_next = '0;
		endcase
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge mclk) begin
		if (sys_rst) reg_rdata <= '0;
		else reg_rdata <= reg_rd ? rdata_next : '0;
	end

	// ==========================================================
	// alarm conditions
	logic [gap_pkg::N_SD-1:0] cond, clr_block, sd_reg, sd_next;
	logic [MEAS_W:0] os_limit;
	logic [MEAS_W-1:0] hc_cnt_reg;
	logic [gap_pkg::EF_ACC_W-1:0] ef_acc_reg;
	logic [gap_pkg::CRANK_W-1:0] crank_cnt_reg;
	logic hc_over, hc_hit, ef_over, ef_curve_hit, warn_reg;

	// start-up margin widens the overspeed trip while starting
	assign os_limit = (overshoot_en && seq.starting) ?
		{1'b0, os_trip_reg} + {1'b0, os_margin_reg} : {1'b0, os_trip_reg};
	assign hc_over = meas.current > hc_trip_reg;
	assign hc_hit = hc_over && (hc_cnt_reg >= hc_period_reg);
	assign ef_over = meas.ef_current > ef_trip_reg;
	assign ef_curve_hit = ef_acc_reg[gap_pkg::EF_ACC_W-1:gap_pkg::EF_ACC_SHIFT] >= ef_curve_reg;

	assign cond[gap_pkg::SD_EARTH] = ef_over && ef_curve_hit;
	// the press that clears the count must not set the alarm again
	assign cond[gap_pkg::SD_START] = !seq.fired && !rst_evt && (crank_max_reg != '0) &&
		(crank_cnt_reg >= crank_max_reg);
	assign cond[gap_pkg::SD_ESTOP] = !estop_s2_reg;
	assign cond[gap_pkg::SD_OIL] = seq.safety_on && (meas.oil < oil_trip_reg);
	assign cond[gap_pkg::SD_TEMP] = seq.safety_on && (meas.temp > temp_trip_reg);
	assign cond[gap_pkg::SD_FUEL] = meas.fuel_rate > fuel_limit_reg;
	assign cond[gap_pkg::SD_ROT] = seq.rot_valid && (seq.rot_reverse != rot_dir);
	assign cond[gap_pkg::SD_OVER] = {1'b0, meas.speed} > os_limit;
	assign cond[gap_pkg::SD_UNDER] = seq.safety_on && (meas.speed < us_trip_reg);
	assign cond[gap_pkg::SD_HICUR] = hc_hit;

	// a reset is refused while the cause stands; the crank count is
	// cleared by the press, so fail to start never blocks its own reset
	assign clr_block = cond & ~(gap_pkg::N_SD'(1) << gap_pkg::SD_START);
	// safety-armed causes are gated by the arming timer, so at rest they
	// are already low and the press clears them

	// excess period counter, restarts when current drops
	always_ff @(posedge mclk) begin
		if (sys_rst || !hc_over) hc_cnt_reg <= '0;
		else if (tick && !hc_hit) hc_cnt_reg <= hc_cnt_reg + 1'b1;
	end

	// inverse time accumulator: grows by the excess, clears at once when at or below trip
	always_ff @(posedge mclk) begin
		if (sys_rst || !ef_over) ef_acc_reg <= '0;
		else if (tick && !(&ef_acc_reg)) ef_acc_reg <= ef_acc_reg +
			gap_pkg::EF_ACC_W'(meas.ef_current - ef_trip_reg);
	end

	// failed crank attempts; firing or a reset press starts over
	always_ff @(posedge mclk) begin
		if (sys_rst || seq.fired || rst_evt) crank_cnt_reg <= '0;
		else if (seq.crank_end && !(&crank_cnt_reg)) crank_cnt_reg <= crank_cnt_reg + 1'b1;
	end

	// ==========================================================
	// latched shutdowns: set wins over the reset press
	genvar gi;
	generate
		for (gi = 0; gi < gap_pkg::N_SD; gi++) begin : g_sd
			assign sd_next[gi] = cond[gi] | (sd_reg[gi] & ~(rst_evt & ~clr_block[gi]));
		end
	endgenerate

	always_ff @(posedge mclk) begin
		if (sys_rst) sd_reg <= '0;
		else sd_reg <= sd_next;
	end

	// high current warning: self-resetting unless latch-all is set
	always_ff @(posedge mclk) begin
		if (sys_rst) warn_reg <= 1'b0;
		else warn_reg <= hc_over | (latch_all & warn_reg & ~rst_evt);
	end

	// protections disabled keeps alarms shown but never stops the set
	assign stop_cmd = (|sd_reg) & ~prot_dis;
	assign sd_alarm = sd_reg;
	assign warn_hicur = warn_reg;
	assign prot_disabled = prot_dis;

	// status and live cause words for software
	assign status_word = {13'h0000, prot_dis, stop_cmd, warn_reg, 6'h00, sd_reg};
	assign cause_word = {15'h0000, hc_over, 6'h00, cond};

	// ==========================================================
	// checks
	sequence s_estop_gone;
		!estop_ok [*3];
	endsequence
	// shutdowns whose cause still stands at a press
	logic [gap_pkg::N_SD-1:0] sd_blocked;
	assign sd_blocked = sd_reg & clr_block;
	sequence s_press_blocked;
		rst_evt && (sd_blocked != '0);
	endsequence

	warn_raise_a: assert property (@(posedge mclk) disable iff (sys_rst)
		hc_over |=> warn_hicur)
		else $error("warning missed overcurrent");
	warn_selfclr_a: assert property (@(posedge mclk) disable iff (sys_rst)
		!latch_all && !hc_over |=> !warn_hicur)
		else $error("warning did not self clear");
	warn_latch_a: assert property (@(posedge mclk) disable iff (sys_rst)
		latch_all && warn_hicur && !rst_evt |=> warn_hicur)
		else $error("latched warning dropped");
	hicur_escal_a: assert property (@(posedge mclk) disable iff (sys_rst)
		$rose(sd_alarm[gap_pkg::SD_HICUR]) |-> $past(hc_over) &&
		($past(hc_cnt_reg) >= $past(hc_period_reg)))
		else $error("high current escalated early");
	hc_restart_a: assert property (@(posedge mclk) disable iff (sys_rst)
		!hc_over |=> hc_cnt_reg == '0)
		else $error("excess counter kept running");
	sd_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
		!rst_evt |=> (sd_alarm & $past(sd_alarm)) == $past(sd_alarm))
		else $error("shutdown dropped without reset");
	stop_drive_a: assert property (@(posedge mclk) disable iff (sys_rst)
		(cond != '0) && !prot_dis && !reg_wr |=> stop_cmd)
		else $error("shutdown did not stop set");
	prot_dis_a: assert property (@(posedge mclk) disable iff (sys_rst)
		prot_disabled |-> !stop_cmd)
		else $error("stop with protections disabled");
	reset_refused_a: assert property (@(posedge mclk) disable iff (sys_rst)
		s_press_blocked |=> (sd_alarm & $past(sd_blocked)) == $past(sd_blocked))
		else $error("reset cleared live shutdown");
	estop_trip_a: assert property (@(posedge mclk) disable iff (sys_rst)
		s_estop_gone |=> sd_alarm[gap_pkg::SD_ESTOP] && stop_cmd == !prot_disabled)
		else $error("emergency stop not honoured");
	oil_armed_a: assert property (@(posedge mclk) disable iff (sys_rst)
		!seq.safety_on && !sd_alarm[gap_pkg::SD_OIL] |=> !sd_alarm[gap_pkg::SD_OIL])
		else $error("oil alarm before safety timer");
	overspeed_a: assert property (@(posedge mclk) disable iff (sys_rst)
		({1'b0, meas.speed} > os_limit) |=> sd_alarm[gap_pkg::SD_OVER])
		else $error("overspeed not latched");

	// margin keeps a starting engine below the widened trip clear
	margin_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
		overshoot_en && seq.starting && !sd_alarm[gap_pkg::SD_OVER] &&
		({1'b0, meas.speed} <= ({1'b0, os_trip_reg} + {1'b0, os_margin_reg}))
		|=> !sd_alarm[gap_pkg::SD_OVER])
		else $error("overspeed tripped inside margin");

	// safety-armed alarms: quiet at rest, latch when armed
	temp_armed_a: assert property (@(posedge mclk) disable iff (sys_rst)
		!seq.safety_on && !sd_alarm[gap_pkg::SD_TEMP] |=> !sd_alarm[gap_pkg::SD_TEMP])
		else $error("temperature alarm before safety timer");
	under_armed_a: assert property (@(posedge mclk) disable iff (sys_rst)
		!seq.safety_on && !sd_alarm[gap_pkg::SD_UNDER] |=> !sd_alarm[gap_pkg::SD_UNDER])
		else $error("underspeed alarm before safety timer");
	oil_trip_a: assert property (@(posedge mclk) disable iff (sys_rst)
		seq.safety_on && (meas.oil < oil_trip_reg) |=> sd_alarm[gap_pkg::SD_OIL])
		else $error("low oil not latched");
	temp_trip_a: assert property (@(posedge mclk) disable iff (sys_rst)
		seq.safety_on && (meas.temp > temp_trip_reg) |=> sd_alarm[gap_pkg::SD_TEMP])
		else $error("high temperature not latched");
	under_trip_a: assert property (@(posedge mclk) disable iff (sys_rst)
		seq.safety_on && (meas.speed < us_trip_reg) |=> sd_alarm[gap_pkg::SD_UNDER])
		else $error("underspeed not latched");
	reset_rest_a: assert property (@(posedge mclk) disable iff (sys_rst)
		rst_evt && !seq.safety_on |=> !sd_alarm[gap_pkg::SD_OIL] &&
		!sd_alarm[gap_pkg::SD_TEMP] && !sd_alarm[gap_pkg::SD_UNDER])
		else $error("armed alarm kept at rest");

	// fuel, rotation and earth comparators
	fuel_trip_a: assert property (@(posedge mclk) disable iff (sys_rst)
		(meas.fuel_rate > fuel_limit_reg) |=> sd_alarm[gap_pkg::SD_FUEL])
		else $error("fuel usage not latched");
	fuel_idle_a: assert property (@(posedge mclk) disable iff (sys_rst)
		(meas.fuel_rate <= fuel_limit_reg) && !sd_alarm[gap_pkg::SD_FUEL]
		|=> !sd_alarm[gap_pkg::SD_FUEL])
		else $error("fuel alarm within limit");
	rot_trip_a: assert property (@(posedge mclk) disable iff (sys_rst)
		seq.rot_valid && (seq.rot_reverse != rot_dir) |=> sd_alarm[gap_pkg::SD_ROT])
		else $error("wrong rotation not latched");
	rot_idle_a: assert property (@(posedge mclk) disable iff (sys_rst)
		!seq.rot_valid && !sd_alarm[gap_pkg::SD_ROT] |=> !sd_alarm[gap_pkg::SD_ROT])
		else $error("rotation alarm without a reading");
	earth_trip_a: assert property (@(posedge mclk) disable iff (sys_rst)
		ef_over && ef_curve_hit |=> sd_alarm[gap_pkg::SD_EARTH])
		else $error("earth fault not latched");
	earth_idle_a: assert property (@(posedge mclk) disable iff (sys_rst)
		!ef_over && !sd_alarm[gap_pkg::SD_EARTH] |=> !sd_alarm[gap_pkg::SD_EARTH])
		else $error("earth fault below trip");

	// escalation waits for the full excess period
	hicur_wait_a: assert property (@(posedge mclk) disable iff (sys_rst)
		hc_over && (hc_cnt_reg < hc_period_reg) && !sd_alarm[gap_pkg::SD_HICUR]
		|=> !sd_alarm[gap_pkg::SD_HICUR])
		else $error("high current escalated before period");

	// fail to start: latch on the count, cleared by firing or a press
	start_fail_a: assert property (@(posedge mclk) disable iff (sys_rst)
		!seq.fired && !rst_evt && (crank_max_reg != '0) &&
		(crank_cnt_reg >= crank_max_reg) |=> sd_alarm[gap_pkg::SD_START])
		else $error("fail to start not latched");
	fired_clr_a: assert property (@(posedge mclk) disable iff (sys_rst)
		seq.fired |=> crank_cnt_reg == '0)
		else $error("crank count kept after firing");
	start_clear_a: assert property (@(posedge mclk) disable iff (sys_rst)
		rst_evt |=> !sd_alarm[gap_pkg::SD_START])
		else $error("fail to start survived a press");
endmodule

// File: bench/gap_plant_model.sv
// gap_plant_model: engine sensors, start flags, emergency stop line and
// stop/reset button facing the alarm block.
// assumes the bench drives it through its tasks; changes land after mclk rises.
`timescale 1ns/1ps
module gap_plant_model (
	input wire logic mclk,
	output gap_pkg::gap_meas_t meas,
	output gap_pkg::gap_seq_t seq,
	output logic estop_ok,
	output logic stop_reset_btn
);
	// ==========================================================
	// plant at rest and healthy at time zero
	initial begin
		meas = '0;
		seq = '0;
		estop_ok = 1'b1;
		stop_reset_btn = 1'b0;
	end
	// level inputs, changed just after an edge
	task automatic set_meas(input gap_pkg::gap_meas_t m);
		@(posedge mclk);
		meas <= m;
	endtask
	task automatic set_seq(input gap_pkg::gap_seq_t s);
		@(posedge mclk);
		seq <= s;
	endtask
	// one failed crank attempt is a single-cycle pulse
	task automatic crank();
		@(posedge mclk);
		seq.crank_end <= 1'b1;
		@(posedge mclk);
		seq.crank_end <= 1'b0;
	endtask
	// failsafe line: low means stop
	task automatic set_estop(input logic v);
		@(posedge mclk);
		estop_ok <= v;
	endtask
	// held two cycles, released long enough for the synchroniser to see low
	task automatic press();
		@(posedge mclk);
		stop_reset_btn <= 1'b1;
		repeat (2) @(posedge mclk);
		stop_reset_btn <= 1'b0;
		repeat (4) @(posedge mclk);
		#1;
	endtask
endmodule

// File: bench/gap_alarm_test.sv
// gap_alarm_test: self-checking bench for the alarm block.
// assumes the plant model on the far side and a short tick for the excess timer.
`timescale 1ns/1ps
module gap_alarm_test;
	localparam int TICK = 4;
	logic mclk, sys_rst, reg_wr, reg_rd, estop_ok, stop_reset_btn;
	logic stop_cmd, warn_hicur, prot_disabled;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rv;
	logic [gap_pkg::N_SD-1:0] sd_alarm;
	gap_pkg::gap_meas_t meas, m;
	gap_pkg::gap_seq_t seq, s;
	logic [15:0] v;
	int err_count, n_checks, seed, k, f;
	// trip settings, written and read back
	logic [7:0] ra [10] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h28};
	logic [15:0] rw [10] = '{16'h0200, 16'h0003, 16'h03e8, 16'h0064, 16'h00c8,
		16'h0032, 16'h005a, 16'h001e, 16'h0064, 16'h0002};

	gap_alarm #(.TICK_CYCLES(TICK)) u_gap_alarm (.mclk(mclk), .sys_rst(sys_rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .meas(meas), .seq(seq), .estop_ok(estop_ok),
		.stop_reset_btn(stop_reset_btn), .stop_cmd(stop_cmd), .warn_hicur(warn_hicur),
		.sd_alarm(sd_alarm), .prot_disabled(prot_disabled));
	gap_plant_model u_plant (.mclk(mclk), .meas(meas), .seq(seq), .estop_ok(estop_ok),
		.stop_reset_btn(stop_reset_btn));

	// ==========================================================
	// clock and watchdog; the whole run needs well under 20000 cycles
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	initial begin
		#400000;
		err_count++;
		close_out();
	end
	// ==========================================================
	// helpers
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		rv = reg_rdata;
	endtask
	function automatic gap_pkg::gap_meas_t safe();
		safe = '{16'h01f4, 16'h0000, 16'h0064, 16'h0032, 16'h0000, 16'h0000};
	endfunction
	task automatic put(input int fld, input logic [15:0] x);
		m = safe();
		case (fld)
		0, 1: m.speed = x;
		2: m.oil = x;
		3: m.temp = x;
		4: m.fuel_rate = x;
		5: m.current = x;
		default: m.ef_current = x;
		endcase
		u_plant.set_meas(m);
	endtask
	// fault removed first, then the press
	task automatic clear();
		u_plant.set_seq('0);
		u_plant.set_meas(safe());
		step(2);
		u_plant.press();
		chk("sd cleared", 32'(sd_alarm), 32'h0);
	endtask
	task automatic wait_sd(input int b);
		for (int i = 0; i < 40 && sd_alarm[b] !== 1'b1; i++) step(1);
	endtask
	// expected latch for one comparator field, strict compares
	function automatic logic [9:0] exp_sd(input int fld, input logic [15:0] x, input logic so);
		exp_sd = '0;
		case (fld)
		0, 1: begin
			exp_sd[gap_pkg::SD_OVER] = x > 16'h03e8;
			exp_sd[gap_pkg::SD_UNDER] = so && x < 16'h00c8;
		end
		2: exp_sd[gap_pkg::SD_OIL] = so && x < 16'h0032;
		3: exp_sd[gap_pkg::SD_TEMP] = so && x > 16'h005a;
		default: exp_sd[gap_pkg::SD_FUEL] = x > 16'h001e;
		endcase
	endfunction
	task automatic close_out();
		if (err_count == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// ==========================================================
	// main sequence
	initial begin
		seed = 6;
		err_count = 0;
		n_checks = 0;
		sys_rst = 1'b1;
		{reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		step(5);
		chk("reset outs", {stop_cmd, warn_hicur, prot_disabled, sd_alarm}, 32'h0);
		sys_rst <= 1'b0;
		// synchroniser starts at stop, so the stop shutdown latches once
		step(4);
		chk("estop boot", {stop_cmd, 21'h0, sd_alarm}, 32'h80000004);
		clear();
		rd(8'h2c);
		chk("crank rst", rv, 32'h3);
		rd(8'h08);
		chk("period rst", rv, 32'h64);
		for (k = 0; k < 10; k++) wr(ra[k], {16'($random(seed)), rw[k]});
		wr(8'h30, 32'hffffffff);
		for (k = 0; k < 10; k++) begin
			rd(ra[k]);
			chk("reg read", rv, {16'h0, rw[k]});
		end
		rd(8'h3c);
		chk("unmapped", rv, 32'h0);
		// estop press refused while still low
		u_plant.set_estop(1'b0);
		step(4);
		u_plant.press();
		chk("estop held", {stop_cmd, 21'h0, sd_alarm}, 32'h80000004);
		u_plant.set_estop(1'b1);
		step(3);
		clear();
		// warning edge at the trip value
		put(5, 16'h0201);
		step(1);
		chk("warn on", warn_hicur, 1'b1);
		put(5, 16'h0200);
		step(1);
		chk("warn off", warn_hicur, 1'b0);
		// brief dips restart the excess count
		put(5, 16'h0201);
		step(7);
		put(5, 16'h0000);
		put(5, 16'h0201);
		step(7);
		chk("no escalate", sd_alarm[gap_pkg::SD_HICUR], 1'b0);
		wait_sd(gap_pkg::SD_HICUR);
		chk("escalate", {stop_cmd, 21'h0, sd_alarm}, 32'h80000200);
		u_plant.press();
		chk("hicur held", sd_alarm[gap_pkg::SD_HICUR], 1'b1);
		clear();
		// latch-all keeps the warning until a press
		wr(8'h00, 32'h1);
		put(5, 16'h0300);
		put(5, 16'h0000);
		step(2);
		chk("warn latched", warn_hicur, 1'b1);
		u_plant.press();
		chk("warn reset", warn_hicur, 1'b0);
		// protections disabled: indicated, no stop
		wr(8'h00, 32'h2);
		u_plant.set_estop(1'b0);
		step(4);
		rd(8'h30);
		chk("prot dis", rv, 32'h00040004);
		chk("prot pins", {30'h0, stop_cmd, prot_disabled}, 32'h1);
		u_plant.set_estop(1'b1);
		step(3);
		clear();
		// start-up margin then plain overspeed
		wr(8'h00, 32'h8);
		s = '0;
		s.starting = 1'b1;
		u_plant.set_seq(s);
		put(0, 16'h0400);
		step(2);
		chk("margin", 32'(sd_alarm), 32'h0);
		u_plant.set_seq('0);
		step(2);
		chk("overspeed", 32'(sd_alarm), 32'h0080);
		clear();
		// phase rotation, all four pairings
		for (k = 0; k < 4; k++) begin
			wr(8'h00, {29'h0, k[1], 2'h0});
			s = '0;
			s.rot_valid = 1'b1;
			s.rot_reverse = k[0];
			u_plant.set_seq(s);
			step(2);
			chk("rotation", sd_alarm[gap_pkg::SD_ROT], k[0] ^ k[1]);
			clear();
		end
		// low oil when armed, reset at rest though still low
		s = '0;
		s.safety_on = 1'b1;
		u_plant.set_seq(s);
		put(2, 16'h0010);
		step(2);
		chk("oil", 32'(sd_alarm), 32'h0008);
		u_plant.set_seq('0);
		u_plant.press();
		chk("oil at rest", 32'(sd_alarm), 32'h0);
		// fail to start on the third attempt
		u_plant.crank();
		u_plant.crank();
		step(2);
		chk("crank 2", sd_alarm[gap_pkg::SD_START], 1'b0);
		u_plant.crank();
		step(2);
		chk("crank 3", sd_alarm[gap_pkg::SD_START], 1'b1);
		clear();
		// firing between attempts starts the count over
		u_plant.crank();
		u_plant.crank();
		s = '0;
		s.fired = 1'b1;
		u_plant.set_seq(s);
		u_plant.set_seq('0);
		u_plant.crank();
		step(2);
		chk("fired restart", sd_alarm[gap_pkg::SD_START], 1'b0);
		clear();
		// earth fault grows along the curve, not at once
		put(6, 16'h0164);
		step(1);
		chk("earth early", sd_alarm[gap_pkg::SD_EARTH], 1'b0);
		wait_sd(gap_pkg::SD_EARTH);
		chk("earth", 32'(sd_alarm), 32'h0001);
		clear();
		// random emergency stop level, latched only when low
		for (k = 0; k < 4; k++) begin
			rv = $random(seed);
			u_plant.set_estop(rv[0]);
			step(4);
			chk("estop rand", {stop_cmd, 21'h0, sd_alarm}, rv[0] ? 32'h0 : 32'h80000004);
			u_plant.set_estop(1'b1);
			step(3);
			clear();
		end
		// random comparator values, armed or at rest
		for (k = 0; k < 40; k++) begin
			f = ($random(seed) & 32'h7fff) % 5;
			v = 16'(($random(seed) & 32'h7fff) % 1200);
			s = '0;
			s.safety_on = 1'($random(seed));
			u_plant.set_seq(s);
			put(f, v);
			step(2);
			chk("random sd", 32'(sd_alarm), 32'(exp_sd(f, v, s.safety_on)));
			clear();
		end
		close_out();
	end
endmodule
